// file: wiper_pkg.sv
// shared constants and carriers for the dual wiper serial loader
package wiper_pkg;
	localparam int WORD_BITS = 10;
	localparam int DATA_BITS = 8;
	localparam int ADDR_HI_POS = 9;
	localparam int ADDR_LO_POS = 8;
	localparam logic [7:0] MIDSCALE = 8'h80;
	localparam logic [1:0] ADDR_CH1 = 2'h0;
	localparam logic [1:0] ADDR_CH2 = 2'h1;

	// analog switch controls for one channel
	typedef struct packed {
		logic term_a_open;
		logic wiper_to_b;
		logic [7:0] code;
	} chan_ctl_s;
endpackage

// file: dual_wiper_serial_loader.sv
// serial loader for a two channel 256 step potentiometer
`timescale 1ns/1ps
// ----------------------------------------
// Notes on behaviour
// ----------------------------------------
// Notes on behaviour
// - word is two address, eight data, MSB first
// - address 00 first latch, 01 second
// - both latches midscale after reset
// - power down opens A, wiper to B
// - power down leaves latches untouched
// - chip select low: shift on clock rise
// - chain output is bit ten shifts earlier
// - clock low: register holds, output enabled
// - chip select rise loads addressed latch
// - only the last ten bits count
// - power down releases chain output
// - channels updated individually, any order
module dual_wiper_serial_loader
	import wiper_pkg::*;
(
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic serial_in,
	input wire logic power_down_n,
	output logic chain_out_o,
	output logic chain_out_oe_n,
	output chan_ctl_s chan1,
	output chan_ctl_s chan2
);
	// ----------------------------------------
	// input synchronisers
	// ----------------------------------------
	logic [3:0] meta_q, meta_d, sync_q, sync_d;
	logic sclk_prev_q, sclk_prev_d, cs_prev_q, cs_prev_d;
	logic sclk_s, cs_s, sdi_s, pd_s;

	always_comb begin
		meta_d = {power_down_n, serial_in, cs_n, sclk};
		sync_d = meta_q;
		sclk_prev_d = sync_q[0];
		cs_prev_d = sync_q[1];
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			// idle pin levels, so no false edge follows reset
			meta_q <= 4'hA;
			sync_q <= 4'hA;
			sclk_prev_q <= 1'b0;
			cs_prev_q <= 1'b1;
		end else begin
			meta_q <= meta_d;
			sync_q <= sync_d;
			sclk_prev_q <= sclk_prev_d;
			cs_prev_q <= cs_prev_d;
		end
	end

	assign sclk_s = sync_q[0];
	assign cs_s = sync_q[1];
	assign sdi_s = sync_q[2];
	assign pd_s = sync_q[3];

	logic shift_ev, load_ev;
	// link is sampled: serial clock must stay below mclk/4
	assign shift_ev = sclk_s & ~sclk_prev_q & ~cs_s;
	assign load_ev = cs_s & ~cs_prev_q;

	// ----------------------------------------
	// address decode
	// ----------------------------------------
	// the two address bits lead the last ten bits shifted in
	function automatic logic [1:0] word_addr(
		input logic [WORD_BITS-1:0] w
	);
		return {w[ADDR_HI_POS], w[ADDR_LO_POS]};
	endfunction

	// ----------------------------------------
	// shift register and latches
	// ----------------------------------------
	// never cleared by chip select: a short word reuses older bits
	logic [WORD_BITS-1:0] shift_reg_q, shift_reg_d;
	logic out_bit_q, out_bit_d;
	logic [DATA_BITS-1:0] latch1_q, latch1_d, latch2_q, latch2_d;

	always_comb begin
		shift_reg_d = shift_reg_q;
		out_bit_d = out_bit_q;
		latch1_d = latch1_q;
		latch2_d = latch2_q;
		if (shift_ev) begin
			// bit pushed out is the one entered ten shifts ago
			out_bit_d = shift_reg_q[WORD_BITS-1];
			shift_reg_d = {shift_reg_q[WORD_BITS-2:0], sdi_s};
		end
		// loading ignores power down so words land during it
		if (load_ev) begin
			if (word_addr(shift_reg_q) == ADDR_CH1) begin
				latch1_d = shift_reg_q[DATA_BITS-1:0];
			end else if (word_addr(shift_reg_q) == ADDR_CH2) begin
				latch2_d = shift_reg_q[DATA_BITS-1:0];
			end
			// the two unused codes fall through and load nothing
		end
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			shift_reg_q <= '0;
			out_bit_q <= 1'b1;
			latch1_q <= MIDSCALE;
			latch2_q <= MIDSCALE;
		end else begin
			shift_reg_q <= shift_reg_d;
			out_bit_q <= out_bit_d;
			latch1_q <= latch1_d;
			latch2_q <= latch2_d;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	// open drain: drive only zero, released when high or powered down
	assign chain_out_o = 1'b0;
	assign chain_out_oe_n = out_bit_q | ~pd_s;

	// switch flags follow the synchronised pin; codes stay in the latches
	always_comb begin
		chan1.term_a_open = ~pd_s;
		chan1.wiper_to_b = ~pd_s;
		chan1.code = latch1_q;
		chan2.term_a_open = ~pd_s;
		chan2.wiper_to_b = ~pd_s;
		chan2.code = latch2_q;
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	// the serial clock is only sampled, so every check runs on mclk
	a_shift_moves_word: assert property (@(posedge mclk) disable iff (sys_rst)
		shift_ev |=> shift_reg_q == {$past(shift_reg_q[8:0]), $past(sdi_s)})
		else $error("shift register did not take the serial bit");

	a_idle_holds_reg: assert property (@(posedge mclk) disable iff (sys_rst)
		!shift_ev |=> $stable(shift_reg_q))
		else $error("shift register changed without a shift");

	a_cs_high_quiet: assert property (@(posedge mclk) disable iff (sys_rst)
		cs_s |=> $stable(shift_reg_q) && $stable(out_bit_q))
		else $error("serial activity seen with chip select high");

	a_chain_delay_ten: assert property (@(posedge mclk) disable iff (sys_rst)
		shift_ev |=> out_bit_q == $past(shift_reg_q[9]))
		else $error("chain output is not the tenth older bit");

	a_chain_holds_bit: assert property (@(posedge mclk) disable iff (sys_rst)
		!shift_ev |=> $stable(out_bit_q))
		else $error("chain bit changed without a shift");

	// open drain: a zero bit pulls the pin low, a one releases it
	a_chain_enabled: assert property (@(posedge mclk) disable iff (sys_rst)
		pd_s && !out_bit_q |-> !chain_out_oe_n && !chain_out_o)
		else $error("chain output not driven low");

	// ----------------------------------------
	// checks on latch loading
	// ----------------------------------------
	a_load_first_ch: assert property (@(posedge mclk) disable iff (sys_rst)
		load_ev && shift_reg_q[9:8] == 2'h0 |=>
		latch1_q == $past(shift_reg_q[7:0]) && $stable(latch2_q))
		else $error("first latch load wrong");

	a_load_second_ch: assert property (@(posedge mclk) disable iff (sys_rst)
		load_ev && shift_reg_q[9:8] == 2'h1 |=>
		latch2_q == $past(shift_reg_q[7:0]) && $stable(latch1_q))
		else $error("second latch load wrong");

	a_load_bad_addr: assert property (@(posedge mclk) disable iff (sys_rst)
		load_ev && shift_reg_q[9] |=>
		$stable(latch1_q) && $stable(latch2_q))
		else $error("unused address changed a latch");

	a_latch_no_load: assert property (@(posedge mclk) disable iff (sys_rst)
		!load_ev |=> $stable(latch1_q) && $stable(latch2_q))
		else $error("latch changed without chip select rise");

	a_load_in_pd: assert property (@(posedge mclk) disable iff (sys_rst)
		load_ev && !pd_s && !shift_reg_q[9] |=>
		($past(shift_reg_q[8]) ? chan2.code : chan1.code) ==
		$past(shift_reg_q[7:0]))
		else $error("word lost during power down");

	// ----------------------------------------
	// checks on power down and reset
	// ----------------------------------------
	a_power_down_out: assert property (@(posedge mclk) disable iff (sys_rst)
		!pd_s |-> chain_out_oe_n && chan1.term_a_open && chan2.wiper_to_b)
		else $error("power down not applied");

	a_flags_follow_pd: assert property (@(posedge mclk) disable iff (sys_rst)
		chan1.term_a_open == !pd_s && chan1.wiper_to_b == !pd_s &&
		chan2.term_a_open == !pd_s && chan2.wiper_to_b == !pd_s)
		else $error("switch flags do not follow power down");

	a_pd_keeps_codes: assert property (@(posedge mclk) disable iff (sys_rst)
		!pd_s && !load_ev |=> $stable(chan1.code) && $stable(chan2.code))
		else $error("power down moved a wiper code");

	// no disable here: this one looks at the release itself
	a_reset_midscale: assert property (@(posedge mclk)
		$fell(sys_rst) |-> latch1_q == 8'h80 && latch2_q == 8'h80)
		else $error("latches not at midscale after reset");
endmodule

// file: host_model.sv
// host side serial driver for the wiper loader
`timescale 1ns/1ps
module host_model (
	input wire logic mclk,
	output logic sclk,
	output logic cs_n,
	output logic serial_in
);
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		serial_in = 1'b0;
	end
	task automatic wt(input int k);
		repeat (k) @(negedge mclk);
	endtask
	// ----
	// one select pulse per word, first bit is the top one
	// ----
	task automatic send(input logic [19:0] w, input int n);
		cs_n = 1'b0;
		wt(3);
		for (int i = n - 1; i >= 0; i--) begin
			serial_in = w[i];
			wt(4);
			sclk = 1'b1;
			wt(4);
			sclk = 1'b0;
		end
		cs_n = 1'b1;
		// released line shows the last bit inverted, not the last bit
		serial_in = ~serial_in;
	endtask
	// ----
	// clock and data wiggle with select high, which must do nothing
	// ----
	task automatic noise(input int n);
		for (int i = 0; i < n; i++) begin
			serial_in = 1'($urandom);
			wt(4);
			sclk = 1'b1;
			wt(4);
			sclk = 1'b0;
		end
	endtask
endmodule

// file: tb_top.sv
// self-checking bench for the dual wiper serial loader
`timescale 1ns/1ps
module tb_top;
	import wiper_pkg::*;
	logic mclk, sys_rst, power_down_n, sclk, cs_n, serial_in, pin, pd;
	logic chain_out_o, chain_out_oe_n;
	logic [19:0] w;
	chan_ctl_s chan1, chan2;
	int n_errors, n_tests, e1, e2;
	int sr_q[$];
	// open drain pin with pull-up
	assign pin = chain_out_oe_n | chain_out_o;
	assign pd = ~power_down_n;
	dual_wiper_serial_loader dual_wiper_serial_loader_inst (.mclk(mclk),
		.sys_rst(sys_rst), .sclk(sclk), .cs_n(cs_n), .serial_in(serial_in),
		.power_down_n(power_down_n), .chain_out_o(chain_out_o),
		.chain_out_oe_n(chain_out_oe_n), .chan1(chan1), .chan2(chan2));
	host_model host_model_inst (.mclk(mclk), .sclk(sclk), .cs_n(cs_n),
		.serial_in(serial_in));
	task automatic check(input logic [9:0] seen, input logic [9:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_errors++;
			$display("mismatch at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	task automatic both();
		repeat (4) @(negedge mclk);
		check(chan1, {pd, pd, 8'(e1)});
		check(chan2, {pd, pd, 8'(e2)});
	endtask
	// ----
	// word sender with the model update; codes 10 and 11 load nothing
	// ----
	task automatic word(input int n, input logic [19:0] v);
		int a, d;
		host_model_inst.send(v, n);
		for (int i = n - 1; i >= 0; i--) sr_q.push_back(int'(v[i]));
		a = 2 * sr_q[$-9] + sr_q[$-8];
		d = 0;
		for (int k = 7; k >= 0; k--) d = 2 * d + sr_q[$-k];
		if (a == 0) e1 = d;
		if (a == 1) e2 = d;
		both();
		check({9'h000, pin}, {9'h000, 1'(pd | sr_q[$-10])});
	endtask
	task automatic summarize();
		if (n_errors == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end
	initial begin
		#5ms;
		n_errors++;
		summarize();
	end
	initial begin
		n_errors = 0;
		n_tests = 0;
		e1 = 128;
		e2 = 128;
		repeat (10) sr_q.push_back(0);
		sys_rst = 1'b1;
		power_down_n = 1'b1;
		void'($urandom(32'h87EE5AE4));
		repeat (20) @(negedge mclk);
		sys_rst = 1'b0;
		both();
		for (int i = 0; i < 12; i++) word(10, 20'($urandom));
		word(13, 20'($urandom));
		w = 20'($urandom);
		word(20, w);
		check({9'h000, pin}, {9'h000, w[10]});
		host_model_inst.noise(6);
		both();
		check({9'h000, pin}, {9'h000, w[10]});
		word(4, 20'($urandom));
		power_down_n = 1'b0;
		both();
		check({9'h000, pin}, 10'h001);
		w = 20'($urandom) & 20'hFFDFF;
		word(10, w);
		power_down_n = 1'b1;
		both();
		summarize();
	end
endmodule
